// ### imcs_pkg.sv
/*
 * Package for the interrupt mode-control slice: register offsets, field
 * positions, reset values and condition encodings.
 * Assumes a 32-bit register port; nothing is imported by users.
 */
package imcs_pkg;
	localparam logic [31:0] mode_ctrl_addr = 32'hffffe004;
	localparam logic [31:0] int_status_addr = 32'hffffe100;
	localparam logic [31:0] int_clear_addr = 32'hffffe104;
	localparam logic [31:0] int_enable_addr = 32'hffffe108;
	localparam int num_src = 3;
	localparam int first_src = 4;
	localparam int src_lane_bits = 8;
	localparam int cond_pos = 4;
	localparam int dma_pos = 3;
	localparam int level_pos = 0;
	localparam logic [5:0] src_field_mask = 6'h3f;
	localparam logic [31:0] mode_ctrl_reset = 32'h00000000;
	localparam logic [1:0] cond_low_level = 2'h0;
	localparam logic [1:0] cond_high_level = 2'h1;
	localparam logic [1:0] cond_fall_edge = 2'h2;
	localparam logic [1:0] cond_rise_edge = 2'h3;
	localparam logic [2:0] level_disabled = 3'h0;
	localparam logic [2:0] max_dma_channel = 3'h3;
	typedef enum logic [2:0] {
		imcs_idle = 3'h1,
		imcs_armed = 3'h2,
		imcs_pending = 3'h4
	} imcs_edge_state_type;
endpackage

// ### imcs_src_if.sv
/*
 * Interface carrying one source's condition field, request and ack, and its detector results
 * between the top module and each per-source detector.
 * Assumes all signals belong to the core_clk domain.
 */
`timescale 1ns/1ps
interface imcs_src_if;
	logic [1:0] cond;
	logic       req_sync;
	logic       ack;
	logic       active;
	logic       rise_seen;
	modport ctrl (output cond, output req_sync, output ack,
		input active, input rise_seen);
	modport det (input cond, input req_sync, input ack,
		output active, output rise_seen);
endinterface

// ### imcs_src_detect.sv
/*
 * Per-source request detector: level modes follow the input, edge modes
 * latch a pending request until acknowledged.
 * Assumes a synchronised request input and one core_clk domain.
 */
`timescale 1ns/1ps
module imcs_src_detect (
	input  wire logic  core_clk,
	input  wire logic  sys_rst,
	imcs_src_if.det    sif
);
	logic                               prev_req;
	logic                               next_prev_req;
	logic                               edge_hit;
	imcs_pkg::imcs_edge_state_type      state;
	imcs_pkg::imcs_edge_state_type      next_state;

	// Edge detection and the pending latch for edge modes.
	always_comb
	begin
		next_prev_req = sif.req_sync;
		edge_hit = 1'b0;
		next_state = state;
		case (sif.cond)
			imcs_pkg::cond_fall_edge: edge_hit = prev_req & ~sif.req_sync;
			imcs_pkg::cond_rise_edge: edge_hit = ~prev_req & sif.req_sync;
			default: edge_hit = 1'b0;
		endcase
		case (state)
			imcs_pkg::imcs_idle: next_state = imcs_pkg::imcs_armed;
			imcs_pkg::imcs_armed:
				if (edge_hit)
				begin
					next_state = imcs_pkg::imcs_pending;
				end
			imcs_pkg::imcs_pending:
				// A new edge in the ack cycle keeps the request.
				if (sif.ack && !edge_hit)
				begin
					next_state = imcs_pkg::imcs_armed;
				end
			default: next_state = imcs_pkg::imcs_idle;
		endcase
		if (!sif.cond[1])
		begin
			next_state = imcs_pkg::imcs_armed;
		end
	end

	// Registers of the detector.
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			prev_req <= 1'b0;
			state <= imcs_pkg::imcs_idle;
		end
		else
		begin
			prev_req <= next_prev_req;
			state <= next_state;
		end
	end

	assign sif.active = sif.cond[1] ? (state == imcs_pkg::imcs_pending)
		: (sif.req_sync == sif.cond[0]);
	assign sif.rise_seen = edge_hit;

	// Edge request is latched as pending; high level follows the input.
	a_edge_pending_hold: assert property (@(posedge core_clk)
		disable iff (sys_rst)
		(sif.cond[1] && edge_hit && state == imcs_pkg::imcs_armed)
		|=> sif.active) else $error("edge request not latched");
	a_level_follow: assert property (@(posedge core_clk)
		disable iff (sys_rst)
		(sif.cond == imcs_pkg::cond_high_level)
		|-> (sif.active == sif.req_sync))
		else $error("high level not followed");
endmodule

// ### imcs_top.sv
/*
 * Interrupt mode-control slice for sources 4 to 6: mode register, request
 * detection, priority or DMA routing, sticky event status and interrupt.
 * Assumes request pins are asynchronous and the register port is a plain
 * one-cycle strobe port on core_clk.
 */
// Added by the designer: the address-and-strobe port.
// Overview of operation
// - Condition field: 00 low, 01 high, 10 falling, 11 rising edge.
// - DMA flag set routes the source request to DMA trigger.
// - Flag clear: level is priority, zero disables the source.
// - Flag set: level field selects DMA channel, not priority.
// - DMA channel values 0 to 3 valid; 4 to 7 invalid.
`timescale 1ns/1ps
module imcs_top #(
	parameter int NUM_SRC = imcs_pkg::num_src
) (
	input  wire logic                 core_clk,
	input  wire logic                 sys_rst,
	input  wire logic [31:0]          reg_addr,
	input  wire logic [31:0]          reg_wdata,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	output logic [31:0]               reg_rdata,
	input  wire logic [NUM_SRC-1:0]   src_req_pin,
	input  wire logic [NUM_SRC-1:0]   src_ack,
	output logic [NUM_SRC-1:0]        int_req,
	output logic [3*NUM_SRC-1:0]      int_priority,
	output logic [NUM_SRC-1:0]        dma_start,
	output logic [2*NUM_SRC-1:0]      dma_channel,
	output logic [NUM_SRC-1:0]        dma_cfg_error,
	output logic                      irq
);
	logic [31:0]        mode_ctrl;
	logic [31:0]        next_mode_ctrl;
	logic [NUM_SRC-1:0] sync1;
	logic [NUM_SRC-1:0] sync2;
	logic [NUM_SRC-1:0] status;
	logic [NUM_SRC-1:0] next_status;
	logic [NUM_SRC-1:0] enable;
	logic [NUM_SRC-1:0] next_enable;
	logic [31:0]        next_rdata;
	logic [NUM_SRC-1:0] active;
	logic [NUM_SRC-1:0] events;
	logic [NUM_SRC-1:0] next_int_req;
	logic [NUM_SRC-1:0] next_dma_start;
	logic [NUM_SRC-1:0] next_cfg_err;
	logic [3*NUM_SRC-1:0] next_prio;
	logic [2*NUM_SRC-1:0] next_chan;
	logic               next_irq;

	// Two-flop synchroniser; the first stage feeds only the second.
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			sync1 <= '0;
			sync2 <= '0;
		end
		else
		begin
			sync1 <= src_req_pin;
			sync2 <= sync1;
		end
	end

	// One detector per source, fields taken from its byte lane.
	for (genvar i = 0; i < NUM_SRC; i++)
	begin : g_src
		imcs_src_if sif ();
		assign sif.cond = mode_ctrl[i*imcs_pkg::src_lane_bits
			+ imcs_pkg::cond_pos +: 2];
		assign sif.req_sync = sync2[i];
		assign sif.ack = src_ack[i];
		assign active[i] = sif.active;
		assign events[i] = sif.rise_seen;
		imcs_src_detect u_det (
			.core_clk (core_clk),
			.sys_rst  (sys_rst),
			.sif      (sif)
		);
	end

	// Register writes and sticky status; set beats clear.
	always_comb
	begin
		next_mode_ctrl = mode_ctrl;
		next_enable = enable;
		next_status = status;
		if (reg_wr)
		begin
			if (reg_addr == imcs_pkg::mode_ctrl_addr)
			begin
				for (int i = 0; i < NUM_SRC; i++)
				begin
					next_mode_ctrl[i*imcs_pkg::src_lane_bits +: 6] =
						reg_wdata[i*imcs_pkg::src_lane_bits +: 6]
						& imcs_pkg::src_field_mask;
				end
			end
			else if (reg_addr == imcs_pkg::int_clear_addr)
			begin
				next_status = status & ~reg_wdata[NUM_SRC-1:0];
			end
			else if (reg_addr == imcs_pkg::int_enable_addr)
			begin
				next_enable = reg_wdata[NUM_SRC-1:0];
			end
		end
		next_status = next_status | events;
	end

	// Read mux; unmapped and write-only addresses read as zero.
	always_comb
	begin
		next_rdata = '0;
		if (reg_rd)
		begin
			if (reg_addr == imcs_pkg::mode_ctrl_addr)
			begin
				next_rdata = mode_ctrl;
			end
			else if (reg_addr == imcs_pkg::int_status_addr)
			begin
				next_rdata[NUM_SRC-1:0] = status;
			end
			else if (reg_addr == imcs_pkg::int_enable_addr)
			begin
				next_rdata[NUM_SRC-1:0] = enable;
			end
		end
	end

	// Routing of each recognised request to interrupt or DMA.
	always_comb
	begin
		next_int_req = '0;
		next_dma_start = '0;
		next_cfg_err = '0;
		next_prio = '0;
		next_chan = '0;
		for (int i = 0; i < NUM_SRC; i++)
		begin
			if (mode_ctrl[i*imcs_pkg::src_lane_bits + imcs_pkg::dma_pos])
			begin
				if (mode_ctrl[i*imcs_pkg::src_lane_bits +: 3]
					<= imcs_pkg::max_dma_channel)
				begin
					next_chan[2*i +: 2] =
						mode_ctrl[i*imcs_pkg::src_lane_bits +: 2];
					next_dma_start[i] = active[i];
				end
				else
				begin
					// Invalid channel: request dropped, flag raised.
					next_cfg_err[i] = 1'b1;
				end
			end
			else
			begin
				next_prio[3*i +: 3] =
					mode_ctrl[i*imcs_pkg::src_lane_bits +: 3];
				next_int_req[i] = active[i]
					&& (next_prio[3*i +: 3] != imcs_pkg::level_disabled);
			end
		end
		next_irq = |(status & enable);
	end

	// Mode, status and enable registers and all outputs.
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			mode_ctrl <= imcs_pkg::mode_ctrl_reset;
			status <= '0;
			enable <= '0;
			reg_rdata <= '0;
			int_req <= '0;
			dma_start <= '0;
			dma_cfg_error <= '0;
			int_priority <= '0;
			dma_channel <= '0;
			irq <= 1'b0;
		end
		else
		begin
			mode_ctrl <= next_mode_ctrl;
			status <= next_status;
			enable <= next_enable;
			reg_rdata <= next_rdata;
			int_req <= next_int_req;
			dma_start <= next_dma_start;
			dma_cfg_error <= next_cfg_err;
			int_priority <= next_prio;
			dma_channel <= next_chan;
			irq <= next_irq;
		end
	end

	// Assertions tying outputs to mode fields.
	a_dma_blocks_int: assert property (@(posedge core_clk)
		disable iff (sys_rst)
		$past(mode_ctrl[imcs_pkg::dma_pos]) |-> !int_req[0])
		else $error("int raised in dma mode");
	a_dma_start_route: assert property (@(posedge core_clk)
		disable iff (sys_rst)
		(mode_ctrl[imcs_pkg::dma_pos] && active[0]
		&& mode_ctrl[2:0] <= imcs_pkg::max_dma_channel) |=> dma_start[0])
		else $error("dma start missing");
	a_prio_disable: assert property (@(posedge core_clk)
		disable iff (sys_rst)
		(mode_ctrl[2:0] == imcs_pkg::level_disabled) |=> !int_req[0])
		else $error("disabled source raised int");
	a_prio_value: assert property (@(posedge core_clk)
		disable iff (sys_rst)
		!mode_ctrl[imcs_pkg::dma_pos] |=> int_priority[2:0]
		== $past(mode_ctrl[2:0]))
		else $error("priority not mirrored");
	a_chan_select: assert property (@(posedge core_clk)
		disable iff (sys_rst)
		(mode_ctrl[imcs_pkg::dma_pos] && !mode_ctrl[2]) |=>
		(dma_channel[1:0] == $past(mode_ctrl[1:0])) && int_priority[2:0] == 0)
		else $error("channel not selected");
	a_chan_invalid: assert property (@(posedge core_clk)
		disable iff (sys_rst)
		(mode_ctrl[imcs_pkg::dma_pos] && mode_ctrl[2]) |=>
		(dma_cfg_error[0] && !dma_start[0]))
		else $error("invalid channel used");
	a_low_level: assert property (@(posedge core_clk)
		disable iff (sys_rst)
		(mode_ctrl[5:4] == imcs_pkg::cond_low_level) |-> active[0] == !sync2[0])
		else $error("low level not decoded");
	// The enable seen by irq is the one of the cycle before, hence $past.
	a_status_sticky: assert property (@(posedge core_clk)
		disable iff (sys_rst)
		events[0] |=> status[0] ##1 (irq || !$past(enable[0])))
		else $error("event not sticky");

	// Per-source checks, so that sources 5 and 6 are guarded as well.
	for (genvar i = 0; i < NUM_SRC; i++)
	begin : g_chk
		localparam int lane = i * imcs_pkg::src_lane_bits;

		a_src_int_route: assert property (@(posedge core_clk)
			disable iff (sys_rst)
			(!mode_ctrl[lane + imcs_pkg::dma_pos] && active[i]
			&& mode_ctrl[lane +: 3] != imcs_pkg::level_disabled)
			|=> int_req[i])
			else $error("enabled request not raised");
		a_src_no_int: assert property (@(posedge core_clk)
			disable iff (sys_rst)
			mode_ctrl[lane + imcs_pkg::dma_pos]
			|=> (!int_req[i] && int_priority[3*i +: 3] == 3'h0))
			else $error("priority used in dma mode");
		a_src_dma_route: assert property (@(posedge core_clk)
			disable iff (sys_rst)
			(mode_ctrl[lane + imcs_pkg::dma_pos] && active[i]
			&& mode_ctrl[lane +: 3] <= imcs_pkg::max_dma_channel)
			|=> dma_start[i])
			else $error("dma trigger not raised");
		a_src_no_dma: assert property (@(posedge core_clk)
			disable iff (sys_rst)
			!mode_ctrl[lane + imcs_pkg::dma_pos] |=> !dma_start[i])
			else $error("dma trigger without dma flag");
		a_src_chan: assert property (@(posedge core_clk)
			disable iff (sys_rst)
			(mode_ctrl[lane + imcs_pkg::dma_pos]
			&& mode_ctrl[lane +: 3] <= imcs_pkg::max_dma_channel)
			|=> (dma_channel[2*i +: 2] == $past(mode_ctrl[lane +: 2])
			&& !dma_cfg_error[i]))
			else $error("valid channel not selected");
		a_src_bad_chan: assert property (@(posedge core_clk)
			disable iff (sys_rst)
			(mode_ctrl[lane + imcs_pkg::dma_pos]
			&& mode_ctrl[lane +: 3] > imcs_pkg::max_dma_channel)
			|=> (dma_cfg_error[i] && !dma_start[i]))
			else $error("invalid channel not refused");
		a_src_prio: assert property (@(posedge core_clk)
			disable iff (sys_rst)
			!mode_ctrl[lane + imcs_pkg::dma_pos]
			|=> int_priority[3*i +: 3] == $past(mode_ctrl[lane +: 3]))
			else $error("priority not taken from level");
		a_src_low_level: assert property (@(posedge core_clk)
			disable iff (sys_rst)
			(mode_ctrl[lane + imcs_pkg::cond_pos +: 2]
			== imcs_pkg::cond_low_level) |-> active[i] == !sync2[i])
			else $error("low level not followed");
		a_src_sticky: assert property (@(posedge core_clk)
			disable iff (sys_rst)
			events[i] |=> status[i])
			else $error("event not recorded");
	end

	// Interrupt output and register port, shared by all sources.
	a_irq_raise: assert property (@(posedge core_clk)
		disable iff (sys_rst)
		|(status & enable) |=> irq)
		else $error("irq missing for enabled status");
	a_irq_drop: assert property (@(posedge core_clk)
		disable iff (sys_rst)
		!(|(status & enable)) |=> !irq)
		else $error("irq without enabled status");
	a_rdata_idle: assert property (@(posedge core_clk)
		disable iff (sys_rst)
		!reg_rd |=> reg_rdata == 32'h0)
		else $error("read data outside read slot");
	a_mode_spare: assert property (@(posedge core_clk)
		disable iff (sys_rst)
		(mode_ctrl & 32'hffc0c0c0) == 32'h0)
		else $error("spare mode bits set");
endmodule

// ### imcs_src_model.sv
/*
 * Model of the request sources and the DMA side of the mode-control slice.
 * Assumes the bench sets the pin levels and whether requests are answered.
 */
`timescale 1ns/1ps
module imcs_src_model (
	input  wire logic       core_clk,
	input  wire logic [2:0] pin_level,
	input  wire logic       ack_en,
	input  wire logic [2:0] int_req,
	input  wire logic [2:0] dma_start,
	output logic [2:0]      src_req_pin,
	output logic [2:0]      src_ack
);
	// Pins start low so the design never sees an unknown request.
	initial
	begin
		src_req_pin = 3'h0;
		src_ack = 3'h0;
	end

	// Pins move just after an edge; acks answer raised requests when allowed.
	always @(posedge core_clk)
	begin
		src_req_pin <= pin_level;
		src_ack <= {3{ack_en}} & (int_req | dma_start);
	end
endmodule

// ### test_interrupt_mode_control_slice.sv
/*
 * Self-checking bench for the interrupt mode-control slice.
 * Assumes the design top and the source model are compiled first.
 */
`timescale 1ns/1ps
module test_interrupt_mode_control_slice;
	logic        core_clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic [31:0] reg_addr = 32'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic [2:0]  pin_level = 3'h0;
	logic        ack_en = 1'b0;
	logic [2:0]  src_req_pin, src_ack, int_req, dma_start, dma_cfg_error;
	logic [8:0]  int_priority;
	logic [5:0]  dma_channel;
	logic        irq;
	int          n_mismatch = 0;
	int          checked = 0;
	int          cycles = 0;

	imcs_top #(.NUM_SRC(3)) i_dut (.core_clk(core_clk), .sys_rst(sys_rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_req_pin(src_req_pin),
		.src_ack(src_ack), .int_req(int_req), .int_priority(int_priority),
		.dma_start(dma_start), .dma_channel(dma_channel),
		.dma_cfg_error(dma_cfg_error), .irq(irq));

	imcs_src_model i_src_model (.core_clk(core_clk), .pin_level(pin_level),
		.ack_en(ack_en), .int_req(int_req), .dma_start(dma_start),
		.src_req_pin(src_req_pin), .src_ack(src_ack));

	// Free-running 125 MHz clock.
	always #4 core_clk = ~core_clk;

	task automatic print_verdict();
		if (n_mismatch == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// A hang ends the run well past the few hundred cycles the tests need.
	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_mismatch++;
			print_verdict();
		end
	end

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe, so look there.
	task automatic rd(input logic [31:0] a, input logic [31:0] exp);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		cmp(reg_rdata, exp);
	endtask

	// Sets pins and ack permission, then lets sync and detection settle.
	task automatic pins(input logic [2:0] v, input logic a);
		@(posedge core_clk);
		pin_level <= v;
		ack_en <= a;
		repeat (8) @(posedge core_clk);
		#1;
	endtask

	task automatic test_regs();
		rd(imcs_pkg::mode_ctrl_addr, imcs_pkg::mode_ctrl_reset);
		wr(imcs_pkg::mode_ctrl_addr, 32'hffffffff);
		rd(imcs_pkg::mode_ctrl_addr, 32'h003f3f3f);
		rd(32'hffffe00c, 32'h0);
		wr(imcs_pkg::int_enable_addr, 32'h7);
		rd(imcs_pkg::int_enable_addr, 32'h7);
		wr(imcs_pkg::int_enable_addr, 32'h0);
		wr(imcs_pkg::mode_ctrl_addr, 32'h0);
	endtask

	// Each condition on source 4: idle, active step, then the step back.
	task automatic test_conds();
		logic [1:0] c;
		logic s;
		for (int i = 0; i < 4; i++)
		begin
			c = i[1:0];
			s = ~c[0];
			wr(imcs_pkg::mode_ctrl_addr, {26'h0, c, 4'h1});
			pins({2'h0, s}, 1'b1);
			pins({2'h0, s}, 1'b0);
			cmp(int_req[0], 1'b0);
			pins({2'h0, ~s}, 1'b0);
			cmp(int_req[0], 1'b1);
			cmp(int_priority[2:0], 3'h1);
			pins({2'h0, s}, 1'b0);
			cmp(int_req[0], c[1]);
		end
	endtask

	task automatic test_irq();
		wr(imcs_pkg::mode_ctrl_addr, 32'h00000031);
		pins(3'h0, 1'b1);
		wr(imcs_pkg::int_clear_addr, 32'h7);
		wr(imcs_pkg::int_enable_addr, 32'h1);
		pins(3'h0, 1'b0);
		cmp(irq, 1'b0);
		pins(3'h1, 1'b0);
		rd(imcs_pkg::int_status_addr, 32'h1);
		cmp(irq, 1'b1);
		wr(imcs_pkg::int_enable_addr, 32'h0);
		pins(3'h1, 1'b0);
		cmp(irq, 1'b0);
		wr(imcs_pkg::int_enable_addr, 32'h1);
		pins(3'h1, 1'b0);
		cmp(irq, 1'b1);
		wr(imcs_pkg::int_clear_addr, 32'h1);
		pins(3'h1, 1'b0);
		cmp(irq, 1'b0);
		rd(imcs_pkg::int_status_addr, 32'h0);
	endtask

	// Edge DMA on sources 4 and 5: latch, hold, then release by ack.
	task automatic test_dma_edge();
		wr(imcs_pkg::mode_ctrl_addr, 32'h0000293a);
		pins(3'h1, 1'b0);
		cmp(dma_start, 3'h1);
		cmp(dma_channel[3:0], 4'h6);
		cmp(int_req, 3'h0);
		pins(3'h3, 1'b0);
		cmp(dma_start, 3'h1);
		pins(3'h1, 1'b1);
		pins(3'h1, 1'b0);
		cmp(dma_start, 3'h0);
		rd(imcs_pkg::int_status_addr, 32'h3);
	endtask

	// Source 6 at high level: every channel setting, then priority mode.
	task automatic test_dma();
		logic [2:0] l;
		for (int i = 0; i < 8; i++)
		begin
			l = i[2:0];
			wr(imcs_pkg::mode_ctrl_addr, {8'h0, 5'h03, l, 16'h0});
			pins(3'h4, 1'b0);
			cmp(dma_start[2], !l[2]);
			cmp(dma_cfg_error[2], l[2]);
			cmp(int_req[2], 1'b0);
			cmp(int_priority[8:6], 3'h0);
			if (!l[2])
				cmp(dma_channel[5:4], l[1:0]);
		end
		wr(imcs_pkg::mode_ctrl_addr, 32'h00100000);
		pins(3'h4, 1'b0);
		cmp(int_req[2], 1'b0);
		wr(imcs_pkg::mode_ctrl_addr, 32'h00160000);
		pins(3'h4, 1'b0);
		cmp(int_req[2], 1'b1);
		cmp(int_priority[8:6], 3'h6);
		cmp(dma_start[2], 1'b0);
	endtask

	// Reset for three cycles, then every scenario in turn.
	initial
	begin
		repeat (3) @(posedge core_clk);
		sys_rst <= 1'b0;
		test_regs();
		test_conds();
		test_irq();
		test_dma();
		test_dma_edge();
		print_verdict();
	end
endmodule
